/* verilog/hpsc_slot_regs.sv */
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
// Summary of operation
// - control bit 0 enables attention button press events
// - control bit 1 enables power fault events
// - control bit 3 enables presence change events
// - control bit 4 enables command completed interrupts
// - control bit 5 is the master hot-plug interrupt enable
// - attention indicator bits 7:6, 01 on 10 blink 11 off, reset 11
// - each attention indicator write sends an attention indicator message
// - power indicator bits 9:8, same encoding, reset 01
// - each power indicator write sends a power indicator message
// - control bit 10 commands slot power, one means off
// - control bit 12 enables link active change notification
// - status bit 16 set on button press, write one clears
// - status bit 17 set on power fault, write one clears
// - status bit 18 reports latch sensor change, read only
// - status bit 19 set on presence change, write one clears
// - status bit 20 set on command completion, write one clears
// - status bit 21 mirrors latch sensor, one means open
// - status bit 22 shows card presence
// - without a slot the presence bit reads one
// - status bit 24 set on link active change, write one clears
module hpsc_slot_regs (
    input  wire logic                                clk,
    input  wire logic                                rstn,
    // apb slave
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [hpsc_pkg::ADDR_W-1:0]         paddr,
    input  wire logic [31:0]                         pwdata,
    input  wire logic [3:0]                          pstrb,
    output logic      [31:0]                         prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    // slot pins, asynchronous
    input  wire logic                                attnButton,
    input  wire logic                                powerFault,
    input  wire logic                                latchOpen,
    input  wire logic                                cardPresent,
    // same-clock inputs
    input  wire logic                                linkActive,
    input  wire logic                                cmdDone,
    input  wire logic                                slotImplemented,
    // slot controls and messages
    output logic      [1:0]                          attnIndicator,
    output logic      [1:0]                          powerIndicator,
    output logic                                     slotPowerOff,
    output hpsc_pkg::hpsc_msg_s                      attnMsg,
    output hpsc_pkg::hpsc_msg_s                      powerMsg,
    output logic                                     hotplugIrq,
    output logic                                     hotplugWake
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [15:0]                ctrl_q;
    logic [15:0]                ctrl_d;
    logic [15:0]                flag_q;
    logic [15:0]                flag_d;
    logic [15:0]                flagSet;
    logic [15:0]                flagClr;
    logic [15:0]                ctrlWm;
    logic [15:0]                statusView;
    logic [31:0]                readWord;
    logic [hpsc_pkg::PIN_N-1:0] pinRaw;
    logic [hpsc_pkg::PIN_N-1:0] pinNow;
    logic [hpsc_pkg::PIN_N-1:0] pinPrev_q;
    logic                       linkPrev_q;
    logic                       setupPh;
    logic                       hitSlot;
    logic                       wrEn;
    logic                       attnWr;
    logic                       pwrWr;
    logic                       pending;
    logic                       wakeAny;
    logic                       presView;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    assign pinRaw = {cardPresent, latchOpen, powerFault, attnButton};

    hpsc_sync3 #(
        .WIDTH (hpsc_pkg::PIN_N)
    ) u_sync (
        .clk    (clk),
        .rstn   (rstn),
        .async  (pinRaw),
        .stable (pinNow)
    );

    // edge history on the settled pin values
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pinPrev_q  <= '0;
            linkPrev_q <= 1'b0;
        end
        else
        begin
            pinPrev_q  <= pinNow;
            linkPrev_q <= linkActive;
        end
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // zero wait: pready goes high for exactly the first access cycle
    assign setupPh = psel && !penable;
    assign hitSlot = (paddr == hpsc_pkg::ADDR_SLOT);
    assign wrEn    = psel && penable && pready && pwrite && hitSlot && !pslverr;
    assign attnWr  = wrEn && pstrb[0];
    assign pwrWr   = wrEn && pstrb[1];

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setupPh;
            pslverr <= setupPh && !hitSlot;
            if (setupPh)
                prdata <= (hitSlot && !pwrite) ? readWord : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // slot control
    // ------------------------------------------------------------
    // byte strobes guard the indicator fields against status-only writes
    assign ctrlWm = {{8{pstrb[1]}}, {8{pstrb[0]}}} & hpsc_pkg::CTRL_WMASK & {16{wrEn}};

    always_comb
    begin
        ctrl_d = (ctrl_q & ~ctrlWm) | (pwdata[15:0] & ctrlWm);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            ctrl_q <= hpsc_pkg::CTRL_RST;
        else
            ctrl_q <= ctrl_d;
    end

    // ------------------------------------------------------------
    // slot status flags
    // ------------------------------------------------------------
    always_comb
    begin
        flagSet = '0;
        flagSet[hpsc_pkg::S_ABP]   = pinNow[hpsc_pkg::PIN_ABP]
                                   && !pinPrev_q[hpsc_pkg::PIN_ABP];
        flagSet[hpsc_pkg::S_PFD]   = pinNow[hpsc_pkg::PIN_PFD]
                                   && !pinPrev_q[hpsc_pkg::PIN_PFD];
        flagSet[hpsc_pkg::S_MRLC]  = pinNow[hpsc_pkg::PIN_MRL]
                                   != pinPrev_q[hpsc_pkg::PIN_MRL];
        flagSet[hpsc_pkg::S_PDC]   = pinNow[hpsc_pkg::PIN_PRS]
                                   != pinPrev_q[hpsc_pkg::PIN_PRS];
        flagSet[hpsc_pkg::S_CC]    = cmdDone;
        flagSet[hpsc_pkg::S_DLLSC] = linkActive != linkPrev_q;
    end

    // latch-change flag has no clear path besides reset
    assign flagClr = pwdata[31:16] & hpsc_pkg::STAT_W1C
                   & {{8{pstrb[3]}}, {8{pstrb[2]}}} & {16{wrEn}};

    always_comb
    begin
        // set wins over a clear in the same cycle
        flag_d = (flag_q & ~flagClr) | flagSet;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            flag_q <= hpsc_pkg::STAT_RST;
        else
            flag_q <= flag_d;
    end

    // ------------------------------------------------------------
    // read view
    // ------------------------------------------------------------
    assign presView = slotImplemented ? pinNow[hpsc_pkg::PIN_PRS] : 1'b1;

    always_comb
    begin
        statusView = flag_q & (hpsc_pkg::STAT_W1C | 16'h0004);
        statusView[hpsc_pkg::S_MRLS] = pinNow[hpsc_pkg::PIN_MRL];
        statusView[hpsc_pkg::S_PDS]  = presView;
        readWord = {statusView, ctrl_q};
    end

    // ------------------------------------------------------------
    // interrupt and wake
    // ------------------------------------------------------------
    always_comb
    begin
        // command completion never wakes, so it is kept out of this term
        wakeAny = (flag_q[hpsc_pkg::S_ABP]   && ctrl_q[hpsc_pkg::C_ABP_EN])
               || (flag_q[hpsc_pkg::S_PFD]   && ctrl_q[hpsc_pkg::C_PFD_EN])
               || (flag_q[hpsc_pkg::S_MRLC]  && ctrl_q[hpsc_pkg::C_MRL_EN])
               || (flag_q[hpsc_pkg::S_PDC]   && ctrl_q[hpsc_pkg::C_PDC_EN])
               || (flag_q[hpsc_pkg::S_DLLSC] && ctrl_q[hpsc_pkg::C_DLLSC_EN]);
        pending = wakeAny
               || (flag_q[hpsc_pkg::S_CC]    && ctrl_q[hpsc_pkg::C_CC_EN]);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            hotplugIrq  <= 1'b0;
            hotplugWake <= 1'b0;
        end
        else
        begin
            hotplugIrq  <= pending && ctrl_q[hpsc_pkg::C_HPI_EN];
            // wake ignores the master enable, for sleeping hosts
            hotplugWake <= wakeAny;
        end
    end

    // ------------------------------------------------------------
    // indicator and power outputs, messages
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            attnIndicator  <= hpsc_pkg::IND_OFF;
            powerIndicator <= hpsc_pkg::IND_ON;
            slotPowerOff   <= 1'b0;
        end
        else
        begin
            attnIndicator  <= ctrl_d[hpsc_pkg::C_ATTN_LO +: 2];
            powerIndicator <= ctrl_d[hpsc_pkg::C_PWRI_LO +: 2];
            slotPowerOff   <= ctrl_d[hpsc_pkg::C_PWR_OFF];
        end
    end

    // a rewrite of the same value still sends a message
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            attnMsg  <= '{valid: 1'b0, code: hpsc_pkg::IND_OFF};
            powerMsg <= '{valid: 1'b0, code: hpsc_pkg::IND_ON};
        end
        else
        begin
            attnMsg.valid  <= attnWr;
            powerMsg.valid <= pwrWr;
            if (attnWr)
                attnMsg.code <= pwdata[hpsc_pkg::C_ATTN_LO +: 2];
            if (pwrWr)
                powerMsg.code <= pwdata[hpsc_pkg::C_PWRI_LO +: 2];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_irq_needs_master: assert property (
        hotplugIrq |-> $past(ctrl_q[hpsc_pkg::C_HPI_EN])
    ) else $error("interrupt without master enable");

    a_irq_follows_flag: assert property (
        (ctrl_q[hpsc_pkg::C_HPI_EN] && ctrl_q[hpsc_pkg::C_CC_EN] && flag_q[hpsc_pkg::S_CC])
        |=> hotplugIrq
    ) else $error("enabled command flag gave no interrupt");

    a_button_flag_set: assert property (
        (pinNow[hpsc_pkg::PIN_ABP] && !pinPrev_q[hpsc_pkg::PIN_ABP])
        |=> flag_q[hpsc_pkg::S_ABP]
    ) else $error("button press not flagged");

    a_fault_flag_set: assert property (
        $rose(pinNow[hpsc_pkg::PIN_PFD]) |=> flag_q[hpsc_pkg::S_PFD] ##1 1'b1
    ) else $error("power fault not flagged");

    a_presence_flag_set: assert property (
        $changed(pinNow[hpsc_pkg::PIN_PRS]) |=> flag_q[hpsc_pkg::S_PDC]
    ) else $error("presence change not flagged");

    a_link_flag_set: assert property (
        (linkActive != $past(linkActive)) |=> flag_q[hpsc_pkg::S_DLLSC]
    ) else $error("link active change not flagged");

    a_cmd_flag_clear: assert property (
        (wrEn && pstrb[2] && pwdata[16 + hpsc_pkg::S_CC] && !cmdDone)
        |=> !flag_q[hpsc_pkg::S_CC]
    ) else $error("command flag not cleared by write one");

    a_attn_msg_sent: assert property (
        attnWr |=> attnMsg.valid && attnMsg.code == $past(pwdata[7:6])
                   && attnIndicator == attnMsg.code
    ) else $error("attention write sent no message");

    a_power_msg_sent: assert property (
        pwrWr |=> powerMsg.valid && powerMsg.code == $past(pwdata[9:8])
                  && powerIndicator == powerMsg.code
    ) else $error("power indicator write sent no message");

    a_no_slot_present: assert property (
        (setupPh && hitSlot && !pwrite && !slotImplemented) |=> prdata[22]
    ) else $error("presence bit low without a slot");

    a_reserved_zero: assert property (
        (prdata[15:13] == 3'h0) && !prdata[23] && (prdata[31:25] == 7'h00)
        && !prdata[11]
    ) else $error("reserved bit reads nonzero");

    a_reset_values: assert property (
        !$past(rstn) |-> attnIndicator == hpsc_pkg::IND_OFF
                         && powerIndicator == hpsc_pkg::IND_ON && !slotPowerOff
    ) else $error("indicator reset values wrong");

    a_power_off_cmd: assert property (
        (wrEn && pstrb[1]) |=> slotPowerOff == $past(pwdata[10])
    ) else $error("slot power does not follow write");

    c_irq_raised: cover property (
        !hotplugIrq ##1 hotplugIrq
    );

    c_attn_blink: cover property (
        attnMsg.valid && attnMsg.code == hpsc_pkg::IND_BLINK
    );

    c_set_and_clear: cover property (
        |(flagSet & flagClr)
    );

endmodule

/* common/hpsc_pkg.sv */
package hpsc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_SLOT      = 12'h0D8;
    localparam int          ADDR_W         = 12;

    // control half, bits 15:0
    localparam int          C_ABP_EN       = 0;
    localparam int          C_PFD_EN       = 1;
    localparam int          C_MRL_EN       = 2;
    localparam int          C_PDC_EN       = 3;
    localparam int          C_CC_EN        = 4;
    localparam int          C_HPI_EN       = 5;
    localparam int          C_ATTN_LO      = 6;
    localparam int          C_PWRI_LO      = 8;
    localparam int          C_PWR_OFF      = 10;
    localparam int          C_DLLSC_EN     = 12;
    localparam logic [15:0] CTRL_WMASK     = 16'h17FF;
    localparam logic [15:0] CTRL_RST       = 16'h01C0;

    // status half, bit index relative to bit 16
    localparam int          S_ABP          = 0;
    localparam int          S_PFD          = 1;
    localparam int          S_MRLC         = 2;
    localparam int          S_PDC          = 3;
    localparam int          S_CC           = 4;
    localparam int          S_MRLS         = 5;
    localparam int          S_PDS          = 6;
    localparam int          S_DLLSC        = 8;
    localparam logic [15:0] STAT_W1C       = 16'h011B;
    localparam logic [15:0] STAT_RST       = 16'h0000;

    // indicator encodings
    localparam logic [1:0]  IND_RSVD       = 2'h0;
    localparam logic [1:0]  IND_ON         = 2'h1;
    localparam logic [1:0]  IND_BLINK      = 2'h2;
    localparam logic [1:0]  IND_OFF        = 2'h3;

    // pin inputs from the slot
    localparam int          PIN_ABP        = 0;
    localparam int          PIN_PFD        = 1;
    localparam int          PIN_MRL        = 2;
    localparam int          PIN_PRS        = 3;
    localparam int          PIN_N          = 4;

    typedef struct packed {
        logic       valid;
        logic [1:0] code;
    } hpsc_msg_s;

endpackage

/* verilog/hpsc_sync3.sv */
`timescale 1ns/1ps
module hpsc_sync3 #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async,
    output logic      [WIDTH-1:0] stable
);
    // ------------------------------------------------------------
    // three stages; stable moves only when stage two and three agree
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic st_q;
            always_ff @(posedge clk)
            begin
                if (!rstn)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    st_q <= 1'b0;
                end
                else
                begin
                    s1_q <= async[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                        st_q <= s3_q;
                end
            end
            assign stable[i] = st_q;
        end
    endgenerate
endmodule

/* verification/hpsc_slot_model.sv */
`timescale 1ns/1ps
module hpsc_slot_model (
    input  wire logic                clk,
    input  wire logic [3:0]          pinReq,
    input  wire hpsc_pkg::hpsc_msg_s attnMsg,
    input  wire hpsc_pkg::hpsc_msg_s powerMsg,
    output logic      [3:0]          pins,
    output logic      [1:0]          attnShown,
    output logic      [1:0]          powerShown
);
    // ------------------------------------------------------------
    // slot pins, skewed off the port clock
    // ------------------------------------------------------------
    // pins are not clock aligned in a real slot, so they move mid-cycle
    always @(pinReq) pins <= #13 pinReq;
    initial pins = 4'h0;

    // ------------------------------------------------------------
    // indicators follow the messages only
    // ------------------------------------------------------------
    initial attnShown = hpsc_pkg::IND_OFF;
    initial powerShown = hpsc_pkg::IND_ON;
    always @(posedge clk)
    begin
        if (attnMsg.valid === 1'b1) attnShown <= attnMsg.code;
        if (powerMsg.valid === 1'b1) powerShown <= powerMsg.code;
    end
endmodule

/* verification/hotplug_slot_ctrl_status_bench.sv */
`timescale 1ns/1ps
module hotplug_slot_ctrl_status_bench;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0]  pstrb = 4'h0, pinReq = 4'h0, pins;
    logic pready, pslverr, linkActive = 0, cmdDone = 0, slotImplemented = 1;
    logic [1:0] attnIndicator, powerIndicator, attnShown, powerShown;
    logic slotPowerOff, hotplugIrq, hotplugWake;
    hpsc_pkg::hpsc_msg_s attnMsg, powerMsg;
    logic [33:0] xq[$];
    logic [1:0]  aq[$], pq[$];
    logic [15:0] expCtrl, expStat, w;
    int failures = 0, comparisons = 0;

    always #25 clk = ~clk;

    hpsc_slot_regs i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .attnButton(pins[0]), .powerFault(pins[1]),
        .latchOpen(pins[2]), .cardPresent(pins[3]), .linkActive(linkActive),
        .cmdDone(cmdDone), .slotImplemented(slotImplemented),
        .attnIndicator(attnIndicator), .powerIndicator(powerIndicator),
        .slotPowerOff(slotPowerOff), .attnMsg(attnMsg), .powerMsg(powerMsg),
        .hotplugIrq(hotplugIrq), .hotplugWake(hotplugWake));

    hpsc_slot_model i_slot (.clk(clk), .pinReq(pinReq), .attnMsg(attnMsg),
        .powerMsg(powerMsg), .pins(pins), .attnShown(attnShown), .powerShown(powerShown));

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // apb master, no cycle count assumed
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [31:0] exp, input logic err);
        int n;
        n = 0;
        xq.push_back({~wr, err, exp});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        if (n >= 40) failures++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd();
        apb(1'b0, hpsc_pkg::ADDR_SLOT, 32'h0, 4'h0, {expStat, expCtrl}, 1'b0);
    endtask

    task automatic wr(input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, hpsc_pkg::ADDR_SLOT, d, s, 32'h0, 1'b0);
    endtask

    // ------------------------------------------------------------
    // output watcher: pops the oldest note per result
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        logic [33:0] x;
        if (psel && penable && pready === 1'b1)
        begin
            x = (xq.size() > 0) ? xq.pop_front() : 34'h0;
            chk({31'h0, pslverr}, {31'h0, x[32]});
            if (x[33]) chk(prdata, x[31:0]);
        end
        // outputs are unknown before the first reset edge
        if (rstn && attnMsg.valid !== 1'b0)
            chk({30'h0, attnMsg.code}, {30'h0, aq.pop_front()});
        if (rstn && powerMsg.valid !== 1'b0)
            chk({30'h0, powerMsg.code}, {30'h0, pq.pop_front()});
    end

    // ------------------------------------------------------------
    // events: 0 button 1 fault 2 latch 3 presence 4 command 5 link
    // ------------------------------------------------------------
    task automatic ev(input int k);
        int b;
        b = (k == 5) ? 8 : k;
        if (k < 4) pinReq[k] <= 1'b1;
        if (k == 4) cmdDone <= 1'b1;
        if (k == 5) linkActive <= ~linkActive;
        @(posedge clk);
        cmdDone <= 1'b0;
        repeat (8) @(posedge clk);
        expStat[b] = 1'b1;
        if (k == 2) expStat[5] = 1'b1;
        if (k == 3) expStat[6] = 1'b1;
        chk({31'h0, hotplugIrq}, {31'h0, k != 2});
        chk({31'h0, hotplugWake}, {31'h0, k != 2 && k != 4});
        rd();
        if (k < 2) pinReq[k] <= 1'b0;
        // the clearing write rewrites both indicator fields, so two messages
        aq.push_back(expCtrl[7:6]);
        pq.push_back(expCtrl[9:8]);
        wr({16'h0 | (16'h1 << b), expCtrl}, 4'hF);
        if (k != 2) expStat[b] = 1'b0;
        rd();
        repeat (2) @(posedge clk);
        chk({31'h0, hotplugIrq}, 32'h0);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        stop_test();
    end

    initial
    begin
        void'($urandom(67203));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk({28'h0, attnIndicator, powerIndicator}, 32'hD);
        chk({31'h0, slotPowerOff | hotplugIrq}, 32'h0);
        expCtrl = hpsc_pkg::CTRL_RST;
        expStat = 16'h0000;
        rd();
        slotImplemented <= 1'b0;
        expStat[6] = 1'b1;
        rd();
        slotImplemented <= 1'b1;
        expStat[6] = 1'b0;
        // all four codes of each indicator, random other bits except bits 5 and 10, held at zero
        for (int i = 0; i < 4; i++)
        begin
            w = 16'($urandom()) & 16'hF81F;
            w = w | 16'(i << 6) | 16'((3 - i) << 8);
            aq.push_back(2'(i));
            pq.push_back(2'(3 - i));
            wr({16'($urandom()) & 16'hFE00, w}, 4'hF);
            expCtrl = w & 16'h17FF;
            repeat (2) @(posedge clk);
            chk({30'h0, attnIndicator}, 32'(i));
            chk({30'h0, powerIndicator}, 32'(3 - i));
            chk({31'h0, slotPowerOff}, {31'h0, w[10]});
            chk({28'h0, attnShown, powerShown}, {28'h0, 2'(i), 2'(3 - i)});
            rd();
        end
        // high byte only: power message alone
        pq.push_back(hpsc_pkg::IND_BLINK);
        wr(32'h0000_0600, 4'h2);
        expCtrl = {8'h06, expCtrl[7:0]};
        rd();
        // unmapped place refused, no write effect
        apb(1'b0, 12'h0DC, 32'h0, 4'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h0DC, 32'hFFFF_FFFF, 4'hF, 32'h0, 1'b1);
        rd();
        aq.push_back(hpsc_pkg::IND_OFF);
        pq.push_back(hpsc_pkg::IND_ON);
        expCtrl = 16'h11FB;
        wr({16'h0, expCtrl}, 4'hF);
        for (int k = 0; k < 6; k++) ev(k);
        // master off: flag still set, no interrupt
        aq.push_back(hpsc_pkg::IND_OFF);
        pq.push_back(hpsc_pkg::IND_ON);
        expCtrl = 16'h11DB;
        wr({16'h0, expCtrl}, 4'hF);
        cmdDone <= 1'b1;
        @(posedge clk);
        cmdDone <= 1'b0;
        repeat (4) @(posedge clk);
        chk({31'h0, hotplugIrq}, 32'h0);
        chk({31'h0, hotplugWake}, 32'h0);
        expStat[4] = 1'b1;
        // wake from a link change while the command flag still stands
        linkActive <= ~linkActive;
        repeat (4) @(posedge clk);
        chk({31'h0, hotplugWake}, 32'h1);
        chk({31'h0, hotplugIrq}, 32'h0);
        expStat[8] = 1'b1;
        rd();
        repeat (4) @(posedge clk);
        chk(32'(xq.size() + aq.size() + pq.size()), 32'h0);
        stop_test();
    end
endmodule
